// >>> rtl/spindle_da_monitor_output.v
`include "spindle_da_monitor_map.vh"
`default_nettype none

module spindle_da_monitor_output #(
   parameter        CYCLE_CNT   = `DA_CYCLE_NS / `DA_CLK_PERIOD_NS,
   parameter [15:0] PHASE_SCALE = 16'h0006,
   parameter        FIFO_DEPTH  = 16,
   parameter        FIFO_AW     = 4
) (
   input  wire        I_CLK,
   input  wire        I_RST_N,
   input  wire [7:0]  I_CHAN1_SOURCE_SELECT,
   input  wire [7:0]  I_CHAN2_SOURCE_SELECT,
   input  wire [15:0] I_CHAN1_SCALE_FACTOR,
   input  wire [15:0] I_CHAN2_SCALE_FACTOR,
   input  wire [15:0] I_SPEED_METER,
   input  wire [15:0] I_LOAD_METER,
   input  wire [15:0] I_CURRENT_CMD,
   input  wire [15:0] I_CURRENT_FB,
   input  wire [15:0] I_SPEED_FB,
   input  wire [31:0] I_POS_DROOP,
   input  wire [31:0] I_POS_FDT,
   input  wire [31:0] I_POS_CMD,
   input  wire [31:0] I_POS_FB,
   input  wire [63:0] I_CTRL_IN,
   input  wire [63:0] I_CTRL_OUT,
   input  wire [15:0] I_U_CURRENT,
   input  wire [15:0] I_V_CURRENT,
   input  wire        I_DAC_READY,
   output wire        O_DAC_VALID,
   output wire [7:0]  O_CH1_CODE,
   output wire [7:0]  O_CH2_CODE,
   output wire [7:0]  O_U_CURRENT_CODE,
   output wire [7:0]  O_V_CURRENT_CODE,
   output wire        O_SAMPLE_SKIPPED
);
   reg  [13:0] cycle_cnt_q;
   reg         tick_q;
   reg  [15:0] sample_q;
   reg         sample_valid_q;
   reg         skipped_q;
   reg  [7:0]  u_code_q;
   reg  [7:0]  v_code_q;
   wire [15:0] ch1_raw;
   wire [15:0] ch2_raw;
   wire [7:0]  ch1_code;
   wire [7:0]  ch2_code;
   wire        fifo_in_ready;
   wire [15:0] fifo_out_data;

   // Picks the raw quantity for one channel; the meter argument is the zero selection.
   // Every source is passed in, because a continuous assignment only wakes on the
   // arguments of a call; a source read inside the body would leave the code stale.
   function [15:0] pick_source;
      input [7:0]  sel;
      input [15:0] meter;
      input [15:0] cur_cmd;
      input [15:0] cur_fb;
      input [15:0] spd_fb;
      input [31:0] droop;
      input [31:0] fdt;
      input [31:0] pcmd;
      input [31:0] pfb;
      input [63:0] cin;
      input [63:0] cout;
      begin
         case (sel)
            `SEL_METER:       pick_source = meter;
            `SEL_CURRENT_CMD: pick_source = cur_cmd;
            `SEL_CURRENT_FB:  pick_source = cur_fb;
            `SEL_SPEED_FB:    pick_source = spd_fb;
            `SEL_DROOP_LO:    pick_source = droop[`WORD_LO];
            `SEL_DROOP_HI:    pick_source = droop[`WORD_HI];
            `SEL_FDT_LO:      pick_source = fdt[`WORD_LO];
            `SEL_FDT_HI:      pick_source = fdt[`WORD_HI];
            `SEL_POS_CMD_LO:  pick_source = pcmd[`WORD_LO];
            `SEL_POS_CMD_HI:  pick_source = pcmd[`WORD_HI];
            `SEL_POS_FB_LO:   pick_source = pfb[`WORD_LO];
            `SEL_POS_FB_HI:   pick_source = pfb[`WORD_HI];
            `SEL_CTRL_IN_1:   pick_source = cin[`CTRL_W1];
            `SEL_CTRL_IN_2:   pick_source = cin[`CTRL_W2];
            `SEL_CTRL_IN_3:   pick_source = cin[`CTRL_W3];
            `SEL_CTRL_IN_4:   pick_source = cin[`CTRL_W4];
            `SEL_CTRL_OUT_1:  pick_source = cout[`CTRL_W1];
            `SEL_CTRL_OUT_2:  pick_source = cout[`CTRL_W2];
            `SEL_CTRL_OUT_3:  pick_source = cout[`CTRL_W3];
            `SEL_CTRL_OUT_4:  pick_source = cout[`CTRL_W4];
            // Unassigned numbers show a flat mid-scale rather than stale data.
            default:          pick_source = 16'h0000;
         endcase
      end
   endfunction

   // Signed multiply by setting/256, then clamp into the signed byte range.
   function [7:0] scale_clamp;
      input [15:0] value;
      input [15:0] setting;
      reg signed [15:0] gain;
      reg signed [31:0] prod;
      reg signed [31:0] shifted;
      begin
         gain = (setting == `SCALE_ZERO) ? `SCALE_UNITY : setting;
         prod = $signed(value) * gain;
         shifted = prod >>> `SCALE_SHIFT;
         if (shifted > `CODE_MAX) begin
            scale_clamp = `CODE_TOP;
         end else if (shifted < `CODE_MIN) begin
            scale_clamp = `CODE_BOTTOM;
         end else begin
            scale_clamp = shifted[7:0];
         end
      end
   endfunction

   // Raw current values keep their 4096 = 100 percent units; only the gain differs.
   assign ch1_raw  = pick_source(I_CHAN1_SOURCE_SELECT, I_SPEED_METER, I_CURRENT_CMD,
                                 I_CURRENT_FB, I_SPEED_FB, I_POS_DROOP, I_POS_FDT, I_POS_CMD,
                                 I_POS_FB, I_CTRL_IN, I_CTRL_OUT);
   assign ch2_raw  = pick_source(I_CHAN2_SOURCE_SELECT, I_LOAD_METER, I_CURRENT_CMD,
                                 I_CURRENT_FB, I_SPEED_FB, I_POS_DROOP, I_POS_FDT, I_POS_CMD,
                                 I_POS_FB, I_CTRL_IN, I_CTRL_OUT);
   assign ch1_code = scale_clamp(ch1_raw, I_CHAN1_SCALE_FACTOR);
   assign ch2_code = scale_clamp(ch2_raw, I_CHAN2_SCALE_FACTOR);

   // Control cycle divider; the tick is a one-cycle enable.
   always @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cycle_cnt_q <= 14'h0000;
         tick_q      <= 1'b0;
      end else if (cycle_cnt_q == CYCLE_CNT[13:0] - 14'h0001) begin
         cycle_cnt_q <= 14'h0000;
         tick_q      <= 1'b1;
      end else begin
         cycle_cnt_q <= cycle_cnt_q + 14'h0001;
         tick_q      <= 1'b0;
      end
   end

   // One sample holds both channels, so the two codes never tear apart in the FIFO.
   // If the FIFO is still full from the last cycle, the new sample is skipped and
   // flagged: keeping the held one preserves order, at the cost of one lost refresh.
   always @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         sample_q       <= 16'h0000;
         sample_valid_q <= 1'b0;
         skipped_q      <= 1'b0;
      end else begin
         skipped_q <= 1'b0;
         if (tick_q) begin
            if (sample_valid_q && !fifo_in_ready) begin
               skipped_q <= 1'b1;
            end else begin
               sample_q       <= {ch2_code, ch1_code};
               sample_valid_q <= 1'b1;
            end
         end else if (sample_valid_q && fifo_in_ready) begin
            sample_valid_q <= 1'b0;
         end
      end
   end

   // Phase current outputs bypass selection and refresh every clock.
   always @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         u_code_q <= 8'h00;
         v_code_q <= 8'h00;
      end else begin
         u_code_q <= scale_clamp(I_U_CURRENT, PHASE_SCALE);
         v_code_q <= scale_clamp(I_V_CURRENT, PHASE_SCALE);
      end
   end

   da_sample_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .I_CLK       (I_CLK),
      .I_RST_N     (I_RST_N),
      .i_in_valid  (sample_valid_q),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (sample_q),
      .o_out_valid (O_DAC_VALID),
      .i_out_ready (I_DAC_READY),
      .o_out_data  (fifo_out_data)
   );

   assign O_CH1_CODE       = fifo_out_data[7:0];
   assign O_CH2_CODE       = fifo_out_data[15:8];
   assign O_U_CURRENT_CODE = u_code_q;
   assign O_V_CURRENT_CODE = v_code_q;
   assign O_SAMPLE_SKIPPED = skipped_q;
endmodule

module da_sample_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             I_CLK,
   input  wire             I_RST_N,
   input  wire             i_in_valid,
   output wire             o_in_ready,
   input  wire [WIDTH-1:0] i_in_data,
   output wire             o_out_valid,
   input  wire             i_out_ready,
   output wire [WIDTH-1:0] o_out_data
);
   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr_q;
   reg  [AW-1:0]    rd_ptr_q;
   reg  [AW:0]      count_q;
   reg              out_valid_q;
   reg  [WIDTH-1:0] out_data_q;
   wire             push;
   wire             pop;

   // The output stage is a register so the converter sees stable codes.
   assign o_in_ready  = (count_q != DEPTH[AW:0]);
   assign push        = i_in_valid && o_in_ready;
   assign pop         = (count_q != {(AW+1){1'b0}}) && (!out_valid_q || i_out_ready);
   assign o_out_valid = out_valid_q;
   assign o_out_data  = out_data_q;

   always @(posedge I_CLK) begin
      if (push) begin
         mem[wr_ptr_q] <= i_in_data;
      end
   end

   always @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         wr_ptr_q    <= {AW{1'b0}};
         rd_ptr_q    <= {AW{1'b0}};
         count_q     <= {(AW+1){1'b0}};
         out_valid_q <= 1'b0;
         out_data_q  <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q   <= rd_ptr_q + 1'b1;
            out_data_q <= mem[rd_ptr_q];
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
         if (pop) begin
            out_valid_q <= 1'b1;
         end else if (i_out_ready) begin
            out_valid_q <= 1'b0;
         end
      end
   end
endmodule

`default_nettype wire

// >>> rtl/spindle_da_monitor_map.vh
`ifndef SPINDLE_DA_MONITOR_MAP_VH
`define SPINDLE_DA_MONITOR_MAP_VH

// Output refresh timing.
`define DA_CYCLE_NS        444000
`define DA_CLK_PERIOD_NS   50

// Source selection numbers.
`define SEL_METER          8'h00
`define SEL_CURRENT_CMD    8'h02
`define SEL_CURRENT_FB     8'h03
`define SEL_SPEED_FB       8'h04
`define SEL_DROOP_LO       8'h06
`define SEL_DROOP_HI       8'h07
`define SEL_FDT_LO         8'h08
`define SEL_FDT_HI         8'h09
`define SEL_POS_CMD_LO     8'h0A
`define SEL_POS_CMD_HI     8'h0B
`define SEL_POS_FB_LO      8'h0C
`define SEL_POS_FB_HI      8'h0D
`define SEL_CTRL_IN_1      8'h50
`define SEL_CTRL_IN_2      8'h51
`define SEL_CTRL_IN_3      8'h52
`define SEL_CTRL_IN_4      8'h53
`define SEL_CTRL_OUT_1     8'h54
`define SEL_CTRL_OUT_2     8'h55
`define SEL_CTRL_OUT_3     8'h56
`define SEL_CTRL_OUT_4     8'h57

// Scaling: gain is setting / 256, a zero setting means unity.
`define SCALE_UNITY        16'h0100
`define SCALE_ZERO         16'h0000
`define SCALE_SHIFT        8

// Signed byte output limits, held at the product width.
`define CODE_MAX           32'sh0000007F
`define CODE_MIN           -32'sh00000080
`define CODE_TOP           8'h7F
`define CODE_BOTTOM        8'h80

// Position and control word fields.
`define WORD_LO            15:0
`define WORD_HI            31:16
`define CTRL_W1            15:0
`define CTRL_W2            31:16
`define CTRL_W3            47:32
`define CTRL_W4            63:48

`endif

// >>> rtl/da_sample_fifo.v
`default_nettype none


`default_nettype wire

// >>> verification/da_calc_pkg.sv
`default_nettype none
package da_calc_pkg;
   // A zero setting stands for unity gain.
   function automatic logic signed [16:0] gain_of(input logic [15:0] s);
      return (s == 16'h0000) ? 17'sh00100 : $signed({s[15], s});
   endfunction
   // Clamping keeps an overdriven trace pinned at the rail instead of wrapping round.
   function automatic logic [7:0] code_of(input logic signed [15:0] v,
                                          input logic signed [16:0] g);
      logic signed [33:0] p;
      p = (v * g) >>> 8;
      if (p > 34'sh7F) return 8'h7F;
      if (p < -34'sh80) return 8'h80;
      return p[7:0];
   endfunction
endpackage
`default_nettype wire

// >>> verification/dac_meter_model.sv
`default_nettype none
module dac_meter_model (
   input  wire logic       i_clk,
   input  wire logic       i_stall,
   input  wire logic       i_valid,
   input  wire logic [7:0] i_ch1,
   input  wire logic [7:0] i_ch2,
   output logic            o_ready,
   output int              o_count,
   output logic [7:0]      o_ch1,
   output logic [7:0]      o_ch2
);
   timeunit 1ns;
   timeprecision 100ps;
   assign o_ready = !i_stall;
   // Both codes of one word are taken on the same edge.
   always @(posedge i_clk) begin
      if (i_valid && o_ready) begin
         o_ch1 <= i_ch1;
         o_ch2 <= i_ch2;
         o_count <= o_count + 1;
      end
   end
endmodule
`default_nettype wire

// >>> verification/spindle_da_monitor_output_chk.sv
`default_nettype none
module da_output_checker import da_calc_pkg::*; #(
   parameter int          CYCLE_CNT   = 20,
   parameter logic [15:0] PHASE_SCALE = 16'h0006
) (
   input wire logic        I_CLK,
   input wire logic        I_RST_N,
   input wire logic [15:0] I_U_CURRENT,
   input wire logic [15:0] I_V_CURRENT,
   input wire logic        I_DAC_READY,
   input wire logic        O_DAC_VALID,
   input wire logic [7:0]  O_CH1_CODE,
   input wire logic [7:0]  O_CH2_CODE,
   input wire logic [7:0]  O_U_CURRENT_CODE,
   input wire logic [7:0]  O_V_CURRENT_CODE,
   input wire logic        O_SAMPLE_SKIPPED
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   int idle_q;
   // A stuck refresh counter would leave the stream silent for good.
   always @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) idle_q <= 0;
      else idle_q <= O_DAC_VALID ? 0 : idle_q + 1;
   end
   sequence s_clear;
      !O_DAC_VALID && O_CH1_CODE == 8'h00 && O_CH2_CODE == 8'h00;
   endsequence
   sequence s_held;
      O_DAC_VALID && $stable(O_CH1_CODE) && $stable(O_CH2_CODE);
   endsequence
   property p_clear; $rose(I_RST_N) |-> s_clear ##0 !O_SAMPLE_SKIPPED; endproperty
   a_clear: assert property (p_clear) else $error("not clear");
   property p_first; $rose(I_RST_N) |-> !O_DAC_VALID [*8]; endproperty
   a_first: assert property (p_first) else $error("early sample");
   property p_u; $past(I_RST_N) |->
      O_U_CURRENT_CODE == code_of($past(I_U_CURRENT), gain_of(PHASE_SCALE)); endproperty
   a_u: assert property (p_u) else $error("u code");
   property p_v; $past(I_RST_N) |->
      O_V_CURRENT_CODE == code_of($past(I_V_CURRENT), gain_of(PHASE_SCALE)); endproperty
   a_v: assert property (p_v) else $error("v code");
   property p_hold; O_DAC_VALID && !I_DAC_READY |=> s_held; endproperty
   a_hold: assert property (p_hold) else $error("word changed");
   property p_pulse; O_SAMPLE_SKIPPED |=> !O_SAMPLE_SKIPPED; endproperty
   a_pulse: assert property (p_pulse) else $error("long skip");
   property p_full; O_SAMPLE_SKIPPED |-> O_DAC_VALID; endproperty
   a_full: assert property (p_full) else $error("skip when empty");
   property p_idle; idle_q <= CYCLE_CNT + 4; endproperty
   a_idle: assert property (p_idle) else $error("no refresh");
endmodule
`default_nettype wire

// >>> verification/tb_spindle_da_monitor_output.sv
`default_nettype none
module tb_spindle_da_monitor_output;
   timeunit 1ns;
   timeprecision 100ps;
   import da_calc_pkg::*;
   localparam int          CYC = 20;
   localparam logic [15:0] PH  = 16'h0006;
   logic        clk = 1'b0, rst_n = 1'b0, stall = 1'b0;
   logic        ready, valid, skipped, skip_seen;
   logic [7:0]  sel1 = 8'h00, sel2 = 8'h00;
   logic [15:0] sc1 = 16'h0000, sc2 = 16'h0000;
   logic [15:0] src[7] = '{default: 16'h0000};
   logic [31:0] pos[4] = '{default: 32'h0};
   logic [63:0] ctrl[2] = '{default: 64'h0};
   logic [7:0]  ch1, ch2, ucode, vcode, m1, m2;
   int          cnt, start, mismatches, compares;
   spindle_da_monitor_output #(.CYCLE_CNT(CYC), .PHASE_SCALE(PH))
   spindle_da_monitor_output_inst (
      .I_CLK(clk), .I_RST_N(rst_n), .I_CHAN1_SOURCE_SELECT(sel1), .I_CHAN2_SOURCE_SELECT(sel2),
      .I_CHAN1_SCALE_FACTOR(sc1), .I_CHAN2_SCALE_FACTOR(sc2), .I_SPEED_METER(src[0]),
      .I_LOAD_METER(src[1]), .I_CURRENT_CMD(src[2]), .I_CURRENT_FB(src[3]), .I_SPEED_FB(src[4]),
      .I_POS_DROOP(pos[0]), .I_POS_FDT(pos[1]), .I_POS_CMD(pos[2]), .I_POS_FB(pos[3]),
      .I_CTRL_IN(ctrl[0]), .I_CTRL_OUT(ctrl[1]), .I_U_CURRENT(src[5]), .I_V_CURRENT(src[6]),
      .I_DAC_READY(ready), .O_DAC_VALID(valid), .O_CH1_CODE(ch1), .O_CH2_CODE(ch2),
      .O_U_CURRENT_CODE(ucode), .O_V_CURRENT_CODE(vcode), .O_SAMPLE_SKIPPED(skipped));
   dac_meter_model dac_meter_model_inst (.i_clk(clk), .i_stall(stall), .i_valid(valid),
      .i_ch1(ch1), .i_ch2(ch2), .o_ready(ready), .o_count(cnt), .o_ch1(m1), .o_ch2(m2));
   always #25 clk = ~clk;
   function automatic logic [15:0] sel_val(input logic second, input logic [7:0] s);
      logic [7:0] k;
      k = s - 8'h50;
      if (s == 8'h00) return second ? src[1] : src[0];
      if (s >= 8'h02 && s <= 8'h04) return src[s];
      if (s >= 8'h06 && s <= 8'h0D) return pos[(s - 8'h06) >> 1][s[0] * 16 +: 16];
      if (s >= 8'h50 && s <= 8'h57) return ctrl[k[2]][k[1:0] * 16 +: 16];
      return 16'h0000;
   endfunction
   function automatic logic [15:0] pick_scale(input int k);
      case (k % 4)
         0: return 16'h0000;
         1: return 16'h0100;
         2: return 16'($urandom_range(48, 1));
         default: return 16'($urandom());
      endcase
   endfunction
   task automatic check_code(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      check_code({7'h00, got}, {7'h00, exp});
   endtask
   task automatic wait_words(input int n);
      int t;
      start = cnt;
      for (t = 0; t < 40 * CYC && cnt < start + n; t++) @(posedge clk);
      #1;
      check_bit(cnt >= start + n, 1'b1);
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hBDFE6F18));
      repeat (6) @(posedge clk);
      #1;
      check_code(ch1, 8'h00);
      check_bit(valid, 1'b0);
      rst_n = 1'b1;
      // Both channels get different numbers, including unassigned ones, at mixed gains.
      for (int i = 0; i < 24; i++) begin
         foreach (src[j]) src[j] = i[0] ? 16'($urandom()) : 16'($urandom_range(400)) - 16'h00C8;
         foreach (pos[j]) pos[j] = $urandom();
         foreach (ctrl[j]) ctrl[j] = {$urandom(), $urandom()};
         sel1 = (i < 15) ? 8'(i) : 8'(i + 65);
         sel2 = ((i + 7) % 24 < 15) ? 8'((i + 7) % 24) : 8'((i + 7) % 24 + 65);
         sc1 = pick_scale(i);
         sc2 = pick_scale(i + 1);
         wait_words(2);
         check_code(m1, code_of(sel_val(1'b0, sel1), gain_of(sc1)));
         check_code(m2, code_of(sel_val(1'b1, sel2), gain_of(sc2)));
         check_code(ucode, code_of(src[5], gain_of(PH)));
         check_code(vcode, code_of(src[6], gain_of(PH)));
      end
      src[2] = 16'h1333;
      sel1 = 8'h02;
      sc1 = 16'h0006;
      src[1] = 16'hFF7F;
      sel2 = 8'h00;
      sc2 = 16'h0000;
      wait_words(2);
      check_code(m1, 8'h73);
      check_code(m2, 8'h80);
      stall = 1'b1;
      skip_seen = 1'b0;
      repeat (20 * CYC) begin
         @(posedge clk);
         #1;
         skip_seen = skip_seen | skipped;
      end
      check_bit(skip_seen, 1'b1);
      start = cnt;
      stall = 1'b0;
      repeat (30) @(posedge clk);
      #1;
      check_bit(cnt - start >= 16, 1'b1);
      rst_n = 1'b0;
      @(posedge clk);
      #1;
      check_bit(valid, 1'b0);
      rst_n = 1'b1;
      wait_words(1);
      check_code(m1, 8'h73);
      end_of_test();
   end
   initial begin
      #(4000 * CYC * 50);
      mismatches++;
      end_of_test();
   end
endmodule
bind spindle_da_monitor_output da_output_checker
   #(.CYCLE_CNT(CYCLE_CNT), .PHASE_SCALE(PHASE_SCALE))
   da_output_checker_inst (.I_CLK, .I_RST_N, .I_U_CURRENT, .I_V_CURRENT, .I_DAC_READY,
   .O_DAC_VALID, .O_CH1_CODE, .O_CH2_CODE, .O_U_CURRENT_CODE, .O_V_CURRENT_CODE,
   .O_SAMPLE_SKIPPED);
`default_nettype wire
